// >>> design/hpp_consts.svh
// hpp_consts.svh: sizes, levels and timing counts of the parallel host port
// assumes a single core clock of 125 MHz shared by both ends
`ifndef HPP_CONSTS_SVH
`define HPP_CONSTS_SVH

// ****************************************
// widths
// ****************************************
`define HPP_ADDR_W        8
`define HPP_DATA_W        16
`define HPP_NARROW_W      8
`define HPP_CNT_W         4

// ****************************************
// pin levels
// ****************************************
`define HPP_ALL_OFF       16'hFFFF
`define HPP_NARROW_OE_N   16'hFF00
`define HPP_NARROW_MASK   16'h00FF
`define HPP_ZERO_DATA     16'h0000
`define HPP_ZERO_ADDR     8'h00

// ****************************************
// timing, in ns as given and in core cycles
// ****************************************
`define HPP_CLK_NS        8
`define HPP_RECOV_NS      120
`define HPP_RD_PULSE_NS   60
`define HPP_WR_PULSE_NS   40
`define HPP_ADDR_SETUP_NS 15
`define HPP_ALE_PULSE_NS  15
`define HPP_CYC(ns)       (((ns) + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_RECOV_CYC     `HPP_CYC(`HPP_RECOV_NS)
`define HPP_RD_CYC        `HPP_CYC(`HPP_RD_PULSE_NS)
`define HPP_WR_CYC        `HPP_CYC(`HPP_WR_PULSE_NS)
`define HPP_SETUP_CYC     `HPP_CYC(`HPP_ADDR_SETUP_NS)
`define HPP_ALE_CYC       `HPP_CYC(`HPP_ALE_PULSE_NS)

`endif

// >>> design/hpp_pkg.sv
// hpp_pkg: types and lane helpers of the parallel host port
// assumes hpp_consts.svh is on the include path
`default_nettype none
`include "hpp_consts.svh"

package hpp_pkg;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {
		HPP_STYLE_ALT = 1'b0, // read-not-write plus data strobe
		HPP_STYLE_SEP = 1'b1  // separate read and write strobes
	} hpp_style_t;

	typedef enum logic [1:0] {
		HPP_DEV_IDLE  = 2'b00,
		HPP_DEV_READ  = 2'b01,
		HPP_DEV_WRITE = 2'b11
	} hpp_dev_state_t;

	typedef enum logic [2:0] {
		HPP_HST_IDLE  = 3'b000,
		HPP_HST_ALE   = 3'b001,
		HPP_HST_SETUP = 3'b011,
		HPP_HST_STRB  = 3'b010,
		HPP_HST_RECV  = 3'b110
	} hpp_host_state_t;

	// ****************************************
	// lane helpers
	// ****************************************
	// keeps only the lanes of the selected data path
	function automatic logic [`HPP_DATA_W-1:0] hpp_mask(input logic [`HPP_DATA_W-1:0] d, input logic wide);
		hpp_mask = wide ? d : (d & `HPP_NARROW_MASK);
	endfunction

	// output enables (low drives) of the selected data path
	function automatic logic [`HPP_DATA_W-1:0] hpp_lanes_oe_n(input logic wide);
		hpp_lanes_oe_n = wide ? `HPP_ZERO_DATA : `HPP_NARROW_OE_N;
	endfunction

endpackage

`default_nettype wire

// >>> design/hpp_bus_if.sv
// hpp_bus_if: pins between the host and the device of the parallel port
// assumes undriven data lines are pulled high on the board
`timescale 1ns/1ps
`default_nettype none
`include "hpp_consts.svh"

interface hpp_bus_if;
	logic                   cs_n;
	logic                   ale;
	logic                   rd_n;
	logic                   wr_n;
	logic                   rnw;
	logic                   data_strobe_n;
	logic                   bus_width_select;
	logic [`HPP_ADDR_W-1:0] addr;
	logic [`HPP_DATA_W-1:0] host_dq_o;
	logic [`HPP_DATA_W-1:0] host_dq_oe_n;
	logic [`HPP_DATA_W-1:0] dev_dq_o;
	logic [`HPP_DATA_W-1:0] dev_dq_oe_n;
	wire  [`HPP_DATA_W-1:0] dq;

	// resolved data lines: released bits read high
	assign dq = (dev_dq_o | dev_dq_oe_n) & (host_dq_o | host_dq_oe_n);

	modport host (
		output cs_n, ale, rd_n, wr_n, rnw, data_strobe_n, bus_width_select, addr,
		output host_dq_o, host_dq_oe_n,
		input  dq
	);

	modport dev (
		input  cs_n, ale, rd_n, wr_n, rnw, data_strobe_n, bus_width_select, addr,
		output dev_dq_o, dev_dq_oe_n,
		input  dq
	);
endinterface

`default_nettype wire

// >>> design/hpp_device.sv
// hpp_device: device end of the asynchronous parallel host port
// assumes all bus pins are asynchronous to core_clk and are synchronised here;
// reg_rdata is a combinational function of reg_addr from the register file
//
// What this block does
// - chip select gates every strobe
// - width pin low 8 bits, high 16
// - latch strobe style during reset, hold it
// - separate style: latch pin edge selects multiplexed
// - host holds latch pin high when demultiplexed, separate style
// - alternate style is demultiplexed only
// - read or write strobe with select starts access
// - write address captured at strobe falling edge
// - host keeps 120 ns between strobes
// - multiplexed address latched from data lines
// - rnw picks direction, data strobe times it
// - host holds latch pin low, alternate style
`timescale 1ns/1ps
`default_nettype none
`include "hpp_consts.svh"

module hpp_device (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// pins
	hpp_bus_if.dev                      bus,
	// register file side
	output logic                        reg_re,
	output logic                        reg_we,
	output logic [`HPP_ADDR_W-1:0]      reg_addr,
	output logic [`HPP_DATA_W-1:0]      reg_wdata,
	input  wire logic [`HPP_DATA_W-1:0] reg_rdata,
	// mode status
	output logic                        style_sep,
	output logic                        muxed_mode,
	output logic                        wide_mode
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [1:0]                 cs_s;
		logic [1:0]                 ale_s;
		logic [1:0]                 rd_s;
		logic [1:0]                 wr_s;
		logic [1:0]                 rnw_s;
		logic [1:0]                 ds_s;
		logic [1:0]                 bws_s;
		logic [`HPP_ADDR_W-1:0]     addr_s0;
		logic [`HPP_ADDR_W-1:0]     addr_s1;
		logic [`HPP_DATA_W-1:0]     dq_s0;
		logic [`HPP_DATA_W-1:0]     dq_s1;
		logic                       ale_prev;
		hpp_pkg::hpp_style_t        style;
		logic                       muxed;
		logic                       wide;
		logic [`HPP_ADDR_W-1:0]     mux_addr;
		hpp_pkg::hpp_dev_state_t    state;
		logic [`HPP_DATA_W-1:0]     acc_wdata;
		logic                       reg_re;
		logic                       reg_we;
		logic [`HPP_ADDR_W-1:0]     reg_addr;
		logic [`HPP_DATA_W-1:0]     reg_wdata;
		logic [`HPP_DATA_W-1:0]     dq_o;
		logic [`HPP_DATA_W-1:0]     dq_oe_n;
	} hpp_dev_st_t;

	hpp_dev_st_t cur;
	hpp_dev_st_t next_st;

	// ****************************************
	// decoded pin levels
	// ****************************************
	logic                   sep;
	logic                   cs_act;
	logic                   rd_act;
	logic                   wr_act;
	logic [`HPP_ADDR_W-1:0] acc_addr;

	// access qualifiers from second-stage samples only
	always_comb begin
		sep      = (cur.style == hpp_pkg::HPP_STYLE_SEP);
		cs_act   = !cur.cs_s[1];
		// separate strobes, or direction line timed by data strobe
		rd_act   = cs_act & (sep ? !cur.rd_s[1] : (!cur.ds_s[1] & cur.rnw_s[1]));
		wr_act   = cs_act & (sep ? !cur.wr_s[1] : (!cur.ds_s[1] & !cur.rnw_s[1]));
		// address from the latch in multiplexed mode, else the pins
		acc_addr = cur.muxed ? cur.mux_addr : cur.addr_s1;
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st = cur;

		// two-stage synchronisers run free, also in reset
		next_st.cs_s    = {cur.cs_s[0], bus.cs_n};
		next_st.ale_s   = {cur.ale_s[0], bus.ale};
		next_st.rd_s    = {cur.rd_s[0], bus.rd_n};
		next_st.wr_s    = {cur.wr_s[0], bus.wr_n};
		next_st.rnw_s   = {cur.rnw_s[0], bus.rnw};
		next_st.ds_s    = {cur.ds_s[0], bus.data_strobe_n};
		next_st.bws_s   = {cur.bws_s[0], bus.bus_width_select};
		next_st.addr_s0 = bus.addr;
		next_st.addr_s1 = cur.addr_s0;
		next_st.dq_s0   = bus.dq;
		next_st.dq_s1   = cur.dq_s0;

		// one-cycle strobes to the register file
		next_st.reg_re  = 1'b0;
		next_st.reg_we  = 1'b0;

		if (!rst_n) begin
			// strobe style follows the latch pin while reset is held
			next_st.style     = hpp_hpp_style(cur.ale_s[1]);
			next_st.ale_prev  = cur.ale_s[1];
			next_st.muxed     = 1'b0;
			next_st.wide      = 1'b0;
			next_st.mux_addr  = `HPP_ZERO_ADDR;
			next_st.state     = hpp_pkg::HPP_DEV_IDLE;
			next_st.acc_wdata = `HPP_ZERO_DATA;
			next_st.reg_addr  = `HPP_ZERO_ADDR;
			next_st.reg_wdata = `HPP_ZERO_DATA;
			next_st.dq_o      = `HPP_ZERO_DATA;
			next_st.dq_oe_n   = `HPP_ALL_OFF;
		end else begin
			// data path width follows its pin
			next_st.wide     = cur.bws_s[1];
			next_st.ale_prev = cur.ale_s[1];

			// in separate style, any latch pin edge after reset means multiplexed; sticky
			if (sep && (cur.ale_s[1] != cur.ale_prev)) begin
				next_st.muxed = 1'b1;
			end

			// latch follows the shared lines while the pin is high
			if (sep && cur.ale_s[1]) begin
				next_st.mux_addr = cur.dq_s1[`HPP_ADDR_W-1:0];
			end

			case (cur.state)
				hpp_pkg::HPP_DEV_IDLE: begin
					if (rd_act) begin
						next_st.state    = hpp_pkg::HPP_DEV_READ;
						next_st.reg_re   = 1'b1;
						next_st.reg_addr = acc_addr;
					end else if (wr_act) begin
						next_st.state     = hpp_pkg::HPP_DEV_WRITE;
						next_st.reg_addr  = acc_addr;
						next_st.acc_wdata = hpp_pkg::hpp_mask(cur.dq_s1, cur.wide);
					end
				end
				hpp_pkg::HPP_DEV_READ: begin
					if (rd_act) begin
						// drive only the lanes in use, refreshed each cycle
						next_st.dq_o    = hpp_pkg::hpp_mask(reg_rdata, cur.wide);
						next_st.dq_oe_n = hpp_pkg::hpp_lanes_oe_n(cur.wide);
					end else begin
						// strobe or select gone: release the lines
						next_st.state   = hpp_pkg::HPP_DEV_IDLE;
						next_st.dq_oe_n = `HPP_ALL_OFF;
					end
				end
				hpp_pkg::HPP_DEV_WRITE: begin
					if (wr_act) begin
						// keep the latest data seen while the strobe is low
						next_st.acc_wdata = hpp_pkg::hpp_mask(cur.dq_s1, cur.wide);
					end else begin
						// strobe end: commit the data held around the edge
						next_st.state     = hpp_pkg::HPP_DEV_IDLE;
						next_st.reg_we    = 1'b1;
						next_st.reg_wdata = cur.acc_wdata;
					end
				end
				default: begin
					next_st.state   = hpp_pkg::HPP_DEV_IDLE;
					next_st.dq_oe_n = `HPP_ALL_OFF;
				end
			endcase
		end
	end

	// style decode from a sampled latch pin level
	function automatic hpp_pkg::hpp_style_t hpp_hpp_style(input logic lvl);
		hpp_hpp_style = lvl ? hpp_pkg::HPP_STYLE_SEP : hpp_pkg::HPP_STYLE_ALT;
	endfunction

	// ****************************************
	// registers
	// ****************************************
	// the whole state moves on every edge
	always_ff @(posedge core_clk) begin
		cur <= next_st;
	end

	// ****************************************
	// outputs, all straight from flops
	// ****************************************
	// pins
	assign bus.dev_dq_o    = cur.dq_o;
	assign bus.dev_dq_oe_n = cur.dq_oe_n;

	// register file side
	assign reg_re          = cur.reg_re;
	assign reg_we          = cur.reg_we;
	assign reg_addr        = cur.reg_addr;
	assign reg_wdata       = cur.reg_wdata;

	// mode status
	assign style_sep       = (cur.style == hpp_pkg::HPP_STYLE_SEP);
	assign muxed_mode      = cur.muxed;
	assign wide_mode       = cur.wide;

endmodule

`default_nettype wire

// >>> design/hpp_host.sv
// hpp_host: host end of the parallel port, one access per command
// assumes the device samples its pins on its own clock; cfg inputs static
`timescale 1ns/1ps
`default_nettype none
`include "hpp_consts.svh"

module hpp_host (
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst_n,
	// pins
	hpp_bus_if.host                     bus,
	// configuration
	input  wire logic                   cfg_alt_style,
	input  wire logic                   cfg_muxed,
	input  wire logic                   cfg_wide,
	// command side
	input  wire logic                   cmd_valid,
	input  wire logic                   cmd_write,
	input  wire logic [`HPP_ADDR_W-1:0] cmd_addr,
	input  wire logic [`HPP_DATA_W-1:0] cmd_wdata,
	output logic                        cmd_ready,
	output logic                        rsp_valid,
	output logic [`HPP_DATA_W-1:0]      rsp_rdata
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [`HPP_DATA_W-1:0]   dq_s0;
		logic [`HPP_DATA_W-1:0]   dq_s1;
		hpp_pkg::hpp_host_state_t state;
		logic [`HPP_CNT_W-1:0]    cnt;
		logic                     write;
		logic [`HPP_DATA_W-1:0]   wdata;
		logic                     cs_n;
		logic                     ale;
		logic                     rd_n;
		logic                     wr_n;
		logic                     rnw;
		logic                     ds_n;
		logic                     bws;
		logic [`HPP_ADDR_W-1:0]   addr;
		logic [`HPP_DATA_W-1:0]   dq_o;
		logic [`HPP_DATA_W-1:0]   dq_oe_n;
		logic                     cmd_ready;
		logic                     rsp_valid;
		logic [`HPP_DATA_W-1:0]   rsp_rdata;
	} hpp_host_st_t;

	hpp_host_st_t cur;
	hpp_host_st_t next_st;
	logic         mux;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st           = cur;
		mux               = cfg_muxed & !cfg_alt_style;
		next_st.dq_s0     = bus.dq;
		next_st.dq_s1     = cur.dq_s0;
		next_st.rsp_valid = 1'b0;
		if (!rst_n) begin
			next_st.state     = hpp_pkg::HPP_HST_IDLE;
			next_st.cnt       = '0;
			next_st.write     = 1'b0;
			next_st.wdata     = `HPP_ZERO_DATA;
			next_st.cs_n      = 1'b1;
			next_st.ale       = !cfg_alt_style;
			next_st.rd_n      = 1'b1;
			next_st.wr_n      = 1'b1;
			next_st.rnw       = 1'b1;
			next_st.ds_n      = 1'b1;
			next_st.bws       = cfg_wide;
			next_st.addr      = `HPP_ZERO_ADDR;
			next_st.dq_o      = `HPP_ZERO_DATA;
			next_st.dq_oe_n   = `HPP_ALL_OFF;
			next_st.cmd_ready = 1'b0;
			next_st.rsp_rdata = `HPP_ZERO_DATA;
		end else begin
			case (cur.state)
				hpp_pkg::HPP_HST_IDLE: begin
					next_st.cmd_ready = 1'b1;
					if (cmd_valid && cur.cmd_ready) begin
						next_st.cmd_ready = 1'b0;
						next_st.write     = cmd_write;
						next_st.wdata     = hpp_pkg::hpp_mask(cmd_wdata, cur.bws);
						next_st.rnw       = !cmd_write;
						// separate address lines idle while the shared lines carry it
						next_st.addr      = mux ? `HPP_ZERO_ADDR : cmd_addr;
						if (mux) begin
							// address onto the shared lines, latch pin high
							next_st.state   = hpp_pkg::HPP_HST_ALE;
							next_st.ale     = 1'b1;
							next_st.dq_o    = {{(`HPP_DATA_W-`HPP_ADDR_W){1'b0}}, cmd_addr};
							next_st.dq_oe_n = hpp_pkg::hpp_lanes_oe_n(cur.bws);
							next_st.cnt     = `HPP_CNT_W'(`HPP_ALE_CYC - 1);
						end else begin
							next_st.state = hpp_pkg::HPP_HST_SETUP;
							next_st.cs_n  = 1'b0;
							next_st.cnt   = `HPP_CNT_W'(`HPP_SETUP_CYC - 1);
						end
					end
				end
				hpp_pkg::HPP_HST_ALE: begin
					next_st.cnt = cur.cnt - 1'b1;
					if (cur.cnt == '0) begin
						// falling latch edge; address stays on the lines
						next_st.state = hpp_pkg::HPP_HST_SETUP;
						next_st.ale   = 1'b0;
						next_st.cs_n  = 1'b0;
						next_st.cnt   = `HPP_CNT_W'(`HPP_SETUP_CYC - 1);
					end
				end
				hpp_pkg::HPP_HST_SETUP: begin
					next_st.cnt = cur.cnt - 1'b1;
					if (cur.cnt == '0) begin
						next_st.state   = hpp_pkg::HPP_HST_STRB;
						next_st.dq_o    = cur.wdata;
						next_st.dq_oe_n = cur.write ? hpp_pkg::hpp_lanes_oe_n(cur.bws) : `HPP_ALL_OFF;
						next_st.rd_n    = !(!cfg_alt_style && !cur.write);
						next_st.wr_n    = !(!cfg_alt_style && cur.write);
						next_st.ds_n    = !cfg_alt_style;
						next_st.cnt     = cur.write ? `HPP_CNT_W'(`HPP_WR_CYC - 1) : `HPP_CNT_W'(`HPP_RD_CYC - 1);
					end
				end
				hpp_pkg::HPP_HST_STRB: begin
					next_st.cnt = cur.cnt - 1'b1;
					if (cur.cnt == '0) begin
						// end of strobe; write data stays through recovery
						next_st.state     = hpp_pkg::HPP_HST_RECV;
						next_st.rd_n      = 1'b1;
						next_st.wr_n      = 1'b1;
						next_st.ds_n      = 1'b1;
						next_st.cs_n      = 1'b1;
						next_st.rsp_valid = !cur.write;
						next_st.rsp_rdata = hpp_pkg::hpp_mask(cur.dq_s1, cur.bws);
						next_st.cnt       = `HPP_CNT_W'(`HPP_RECOV_CYC - 1);
					end
				end
				hpp_pkg::HPP_HST_RECV: begin
					next_st.cnt = cur.cnt - 1'b1;
					if (cur.cnt == '0) begin
						next_st.state     = hpp_pkg::HPP_HST_IDLE;
						next_st.dq_oe_n   = `HPP_ALL_OFF;
						next_st.cmd_ready = 1'b1;
					end
				end
				default: begin
					next_st.state = hpp_pkg::HPP_HST_IDLE;
				end
			endcase
		end
	end

	// whole state moves on every edge
	always_ff @(posedge core_clk) begin
		cur <= next_st;
	end

	// ****************************************
	// outputs, all straight from flops
	// ****************************************
	assign bus.cs_n             = cur.cs_n;
	assign bus.ale              = cur.ale;
	assign bus.rd_n             = cur.rd_n;
	assign bus.wr_n             = cur.wr_n;
	assign bus.rnw              = cur.rnw;
	assign bus.data_strobe_n    = cur.ds_n;
	assign bus.bus_width_select = cur.bws;
	assign bus.addr             = cur.addr;
	assign bus.host_dq_o        = cur.dq_o;
	assign bus.host_dq_oe_n     = cur.dq_oe_n;
	assign cmd_ready            = cur.cmd_ready;
	assign rsp_valid            = cur.rsp_valid;
	assign rsp_rdata            = cur.rsp_rdata;

endmodule

`default_nettype wire

// >>> verif/hpp_bus_chk.sv
// hpp_bus_chk: assertions on the pins between the host and device ends
// assumes one core clock, synchronous active-low reset, plain pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "hpp_consts.svh"

module hpp_bus_chk (
	// clock and reset
	input wire logic                   core_clk,
	input wire logic                   rst_n,
	// selects and strobes
	input wire logic                   cs_n,
	input wire logic                   ale,
	input wire logic                   rd_n,
	input wire logic                   wr_n,
	input wire logic                   rnw,
	input wire logic                   data_strobe_n,
	input wire logic                   bus_width_select,
	// data lanes
	input wire logic [`HPP_DATA_W-1:0] host_dq_o,
	input wire logic [`HPP_DATA_W-1:0] host_dq_oe_n,
	input wire logic [`HPP_DATA_W-1:0] dev_dq_oe_n
);
	logic       alt_q;
	logic [4:0] gap;
	logic       strb;

	// any strobe active
	assign strb = !rd_n || !wr_n || !data_strobe_n;

	// strap copy taken in reset, and count of strobe-free cycles
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			alt_q <= !ale;
			gap   <= 5'h1F;
		end else begin
			gap <= strb ? 5'h00 : ((gap == 5'h1F) ? gap : gap + 5'h01);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ****************************************
	// sequences
	// ****************************************
	// a selected read strobe starts
	sequence s_rd_start;
		($fell(rd_n) || ($fell(data_strobe_n) && rnw)) && !cs_n;
	endsequence

	// address latched, strobe follows after the setup gap
	sequence s_mux_setup;
		(rd_n && wr_n)[*2] ##[1:2] (!rd_n || !wr_n);
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	a_rd_pulse: assert property ($fell(rd_n) |-> (!rd_n && !cs_n)[*8] ##1 rd_n)
		else $error("read strobe width or select wrong");
	a_wr_pulse: assert property ($fell(wr_n) |-> (!wr_n && !cs_n)[*5] ##1 wr_n)
		else $error("write strobe width or select wrong");
	a_ds_timing: assert property ($fell(data_strobe_n) |->
		(!data_strobe_n && !cs_n && $stable(rnw))[*5] ##[1:4] data_strobe_n)
		else $error("data strobe access malformed");
	a_rd_drive: assert property (s_rd_start |-> ##[2:6] (dev_dq_oe_n != `HPP_ALL_OFF))
		else $error("device did not drive read data");
	a_rd_release: assert property (($rose(rd_n) || ($rose(data_strobe_n) && $past(rnw))) |->
		##[1:4] (dev_dq_oe_n == `HPP_ALL_OFF))
		else $error("device kept data lines after read");
	a_wr_no_drive: assert property ((!cs_n && (!wr_n || (!rnw && !data_strobe_n))) |->
		dev_dq_oe_n == `HPP_ALL_OFF)
		else $error("device drove lines during write");
	a_narrow_lanes: assert property (!bus_width_select |-> dev_dq_oe_n[15:8] == 8'hFF)
		else $error("upper lanes driven in narrow mode");
	a_wide_lanes: assert property ((bus_width_select && dev_dq_oe_n != `HPP_ALL_OFF) |->
		dev_dq_oe_n == `HPP_ZERO_DATA)
		else $error("partial lanes driven in wide mode");
	a_strobe_recov: assert property ($rose(strb) |-> gap >= 5'h0F)
		else $error("strobes closer than recovery time");
	a_cs_release: assert property (cs_n[*5] |-> (dev_dq_oe_n == `HPP_ALL_OFF))
		else $error("device drove lines without chip select");
	a_alt_ale_low: assert property (alt_q |-> !ale)
		else $error("latch pin moved in alternate style");
	a_mux_addr: assert property ($rose(ale) |->
		##1 (ale && $stable(host_dq_o[7:0]) && host_dq_oe_n[7:0] == 8'h00))
		else $error("address not held during latch pulse");
	a_mux_setup: assert property (($fell(ale) && !cs_n) |-> s_mux_setup)
		else $error("strobe too soon after address latch");
	a_wdata_hold: assert property (($rose(wr_n) || ($rose(data_strobe_n) && !$past(rnw))) |->
		(host_dq_oe_n[7:0] == 8'h00 && $stable(host_dq_o))[*3])
		else $error("write data not held past strobe end");
endmodule

`default_nettype wire

// >>> verif/host_parallel_bus_port_tb.sv
// host_parallel_bus_port_tb: host and device ends joined, driven on the command side
// assumes the register file answers combinationally from the register address
`timescale 1ns/1ps
`default_nettype none
`include "hpp_consts.svh"

module host_parallel_bus_port_tb;
	logic                   core_clk;
	logic                   rst_n;
	logic                   cfg_alt_style;
	logic                   cfg_muxed;
	logic                   cfg_wide;
	logic                   cmd_valid;
	logic                   cmd_write;
	logic [`HPP_ADDR_W-1:0] cmd_addr;
	logic [`HPP_DATA_W-1:0] cmd_wdata;
	logic                   cmd_ready;
	logic                   rsp_valid;
	logic [`HPP_DATA_W-1:0] rsp_rdata;
	logic                   reg_re;
	logic                   reg_we;
	logic [`HPP_ADDR_W-1:0] reg_addr;
	logic [`HPP_DATA_W-1:0] reg_wdata;
	logic [`HPP_DATA_W-1:0] reg_rdata;
	logic                   style_sep;
	logic                   muxed_mode;
	logic                   wide_mode;
	logic [`HPP_ADDR_W-1:0] seen_addr;
	logic [`HPP_DATA_W-1:0] seen_data;
	int                     n_errors = 0;
	int                     n_compared = 0;
	int                     n_cycles = 0;

	// register file stand-in: data is a fixed function of the address
	assign reg_rdata = {reg_addr ^ 8'hA5, reg_addr};

	// ****************************************
	// ends, carrier and checker
	// ****************************************
	hpp_bus_if hpp_bus_if_inst ();
	hpp_device hpp_device_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(hpp_bus_if_inst.dev),
		.reg_re(reg_re), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .style_sep(style_sep), .muxed_mode(muxed_mode), .wide_mode(wide_mode));
	hpp_host hpp_host_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(hpp_bus_if_inst.host),
		.cfg_alt_style(cfg_alt_style), .cfg_muxed(cfg_muxed), .cfg_wide(cfg_wide),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	hpp_bus_chk hpp_bus_chk_inst (.core_clk(core_clk), .rst_n(rst_n), .cs_n(hpp_bus_if_inst.cs_n),
		.ale(hpp_bus_if_inst.ale), .rd_n(hpp_bus_if_inst.rd_n), .wr_n(hpp_bus_if_inst.wr_n),
		.rnw(hpp_bus_if_inst.rnw), .data_strobe_n(hpp_bus_if_inst.data_strobe_n),
		.bus_width_select(hpp_bus_if_inst.bus_width_select), .host_dq_o(hpp_bus_if_inst.host_dq_o),
		.host_dq_oe_n(hpp_bus_if_inst.host_dq_oe_n), .dev_dq_oe_n(hpp_bus_if_inst.dev_dq_oe_n));

	// 125 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ****************************************
	// tasks
	// ****************************************
	// verdict and end of run
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// one comparison
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// reset with a new configuration held through it
	task automatic do_reset(input logic [2:0] c);
		@(posedge core_clk);
		cfg_alt_style <= c[2];
		cfg_muxed     <= c[1];
		cfg_wide      <= c[0];
		rst_n         <= 1'b0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge core_clk);
	endtask

	// one command, then catch the register side or the answer
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
		int k;
		seen_addr = 'x;
		seen_data = 'x;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 60) begin
			@(negedge core_clk);
			k++;
		end
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd_write <= wr;
		cmd_addr  <= a;
		cmd_wdata <= d;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		for (k = 0; k < 40; k++) begin
			@(negedge core_clk);
			if (reg_we === 1'b1 || reg_re === 1'b1) seen_addr = reg_addr;
			if (reg_we === 1'b1) seen_data = reg_wdata;
			if (rsp_valid === 1'b1) seen_data = rsp_rdata;
			if ((wr && reg_we === 1'b1) || (!wr && rsp_valid === 1'b1)) break;
		end
	endtask

	// cycle ceiling against hangs
	always @(posedge core_clk) begin
		n_cycles <= n_cycles + 1;
		if (n_cycles == 5000) begin
			n_errors = n_errors + 1;
			wrap_up();
		end
	end

	// ****************************************
	// tests: {alt style, muxed, wide} per pass
	// ****************************************
	initial begin
		logic [2:0]  tab [6];
		logic [2:0]  c;
		logic [7:0]  a;
		logic [15:0] d;
		logic [15:0] msk;
		rst_n         = 1'b0;
		cfg_alt_style = 1'b0;
		cfg_muxed     = 1'b0;
		cfg_wide      = 1'b1;
		cmd_valid     = 1'b0;
		cmd_write     = 1'b0;
		cmd_addr      = 8'h00;
		cmd_wdata     = 16'h0000;
		tab = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h6};
		for (int i = 0; i < 6; i++) begin
			c = tab[i];
			msk = c[0] ? 16'hFFFF : 16'h00FF;
			do_reset(c);
			check("style_sep", {15'h0000, !c[2]}, {15'h0000, style_sep});
			check("wide_mode", {15'h0000, c[0]}, {15'h0000, wide_mode});
			check("muxed_mode", 16'h0000, {15'h0000, muxed_mode});
			// back-to-back writes at both address ends
			for (int j = 0; j < 2; j++) begin
				a = j ? 8'h00 : 8'hFF;
				d = 16'hA5C3 ^ 16'(i * 257 + j * 4369);
				access(1'b1, a, d);
				check("write addr", {8'h00, a}, {8'h00, seen_addr});
				check("write data", d & msk, seen_data);
			end
			// back-to-back reads
			for (int j = 0; j < 2; j++) begin
				a = j ? 8'hFF : 8'h5A;
				access(1'b0, a, 16'h0000);
				check("read addr", {8'h00, a}, {8'h00, seen_addr});
				check("read data", {a ^ 8'hA5, a} & msk, seen_data);
			end
			check("muxed_mode", {15'h0000, c[1] & !c[2]}, {15'h0000, muxed_mode});
			$display("test %0d done: alt %0b muxed %0b wide %0b", i, c[2], c[1], c[0]);
		end
		wrap_up();
	end
endmodule

`default_nettype wire
